// ===== tsp_smbus_slave.sv
`timescale 1ns/1ns
`default_nettype none

// Serial slave port of the temperature sensor, sampling the bus pins.
module tsp_smbus_slave #(
   parameter logic [6:0] SLAVE_ADDR = tsp_pkg::ADDR_VAR_B,
   parameter logic [7:0] MAKER_ID = 8'h3a, // Value is arbitrary.
   parameter int unsigned TIMEOUT_CYCLES = tsp_pkg::TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output var logic sda_out,
   output var logic sda_oe,
   input wire tsp_pkg::tsp_temp_s temps,
   input wire logic temp_update,
   input wire logic [7:0] status_flags,
   output var tsp_pkg::tsp_settings_s settings,
   output var logic high_speed_bus_mode,
   output var logic one_shot_start,
   output var logic status_read
);
   import tsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling and bus condition detection.

   logic scl_s;
   logic sda_s;
   logic scl_q;
   logic sda_q;

   tsp_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .clock(clock),
      .reset(reset),
      .pin(scl_in),
      .level(scl_s)
   );

   tsp_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .clock(clock),
      .reset(reset),
      .pin(sda_in),
      .level(sda_s)
   );

   // Previous synchronised levels for edge detection.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // Data changing while the clock stays high marks start and stop.
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
   assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // Transfer state.

   tsp_state_e state_r;
   logic [7:0] sh_r;
   logic [2:0] bit_cnt_r;
   logic rw_r;
   logic ack_ph_r;
   logic ptr_phase_r;
   logic tx_done_r;
   logic nack_r;
   logic [7:0] ptr_r;
   logic [7:0] rd_data;
   logic [7:0] byte_in;
   logic byte_done;
   logic wr_fire;
   logic rd_fire;
   logic to_fire;
   logic [TO_W-1:0] to_cnt_r;

   // Byte completes on the eighth rising clock edge.
   assign byte_in = {sh_r[6:0], sda_s};
   assign byte_done = scl_rise && (bit_cnt_r == 3'h7);
   assign wr_fire = (state_r == ST_RX) && byte_done && !ptr_phase_r;
   assign rd_fire = scl_fall && ((state_r == ST_ACK && ack_ph_r && rw_r) ||
                    (state_r == ST_MACK && !nack_r));

   // Bus state machine; start wins over everything but reset and timeout.
   always_ff @(posedge clock)
   begin
      if (reset || to_fire)
      begin
         state_r <= ST_IDLE;
      end
      else if (bus_start)
      begin
         state_r <= ST_ADDR;
      end
      else if (bus_stop)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         case (state_r)
            ST_ADDR:
               if (byte_done)
               begin
                  if (byte_in[7:3] == HS_CODE_PFX)
                     state_r <= ST_WAIT;
                  else if (byte_in[7:1] == SLAVE_ADDR)
                     state_r <= ST_ACK;
                  else
                     state_r <= ST_WAIT;
               end
            ST_ACK:
               if (scl_fall && ack_ph_r)
                  state_r <= rw_r ? ST_TX : ST_RX;
            ST_RX:
               if (byte_done)
                  state_r <= ST_ACK;
            ST_TX:
               if (scl_fall && tx_done_r)
                  state_r <= ST_MACK;
            ST_MACK:
               if (scl_fall)
                  state_r <= nack_r ? ST_WAIT : ST_TX;
            ST_IDLE, ST_WAIT:
               state_r <= state_r;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // Bit counter, shift register and phase flags.
   always_ff @(posedge clock)
   begin
      if (reset || bus_start || bus_stop || to_fire)
      begin
         sh_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         ack_ph_r <= 1'b0;
         tx_done_r <= 1'b0;
         nack_r <= 1'b0;
         if (reset || bus_start || to_fire)
            rw_r <= 1'b0;
         ptr_phase_r <= 1'b1;
      end
      else
      begin
         if (rd_fire)
         begin
            sh_r <= rd_data;
            bit_cnt_r <= 3'h0;
            tx_done_r <= 1'b0;
         end
         else if (scl_rise && (state_r == ST_ADDR || state_r == ST_RX))
         begin
            sh_r <= byte_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
         else if (scl_rise && state_r == ST_TX)
         begin
            sh_r <= {sh_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            tx_done_r <= (bit_cnt_r == 3'h7);
         end
         if (state_r == ST_ADDR && byte_done)
            rw_r <= sda_s;
         if (wr_fire || (state_r == ST_RX && byte_done))
            ptr_phase_r <= 1'b0;
         if (state_r == ST_ACK && scl_fall)
            ack_ph_r <= ~ack_ph_r;
         if (state_r == ST_MACK && scl_rise)
            nack_r <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data line drive: acknowledge and read data, changed on falling clock.

   always_ff @(posedge clock)
   begin
      if (reset || bus_start || bus_stop || to_fire)
      begin
         sda_oe <= 1'b0;
      end
      else if (scl_fall)
      begin
         case (state_r)
            ST_ACK:
               sda_oe <= ack_ph_r ? (rw_r & ~rd_data[7]) : 1'b1;
            ST_TX:
               sda_oe <= tx_done_r ? 1'b0 : ~sh_r[7];
            ST_MACK:
               sda_oe <= nack_r ? 1'b0 : ~rd_data[7];
            default:
               sda_oe <= 1'b0;
         endcase
      end
   end

   // The pin is open drain: only a low level is ever driven.
   always_ff @(posedge clock)
   begin
      sda_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer register.

   always_ff @(posedge clock)
   begin
      if (reset)
         ptr_r <= PTR_RST;
      else if (state_r == ST_RX && byte_done && ptr_phase_r)
         ptr_r <= byte_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus stuck timeout, counted while a line is held low in a transfer.

   always_ff @(posedge clock)
   begin
      if (reset || !settings.fault_count_and_timeout[TIMEOUT_EN_BIT] ||
          state_r == ST_IDLE || (scl_s && sda_s))
         to_cnt_r <= '0;
      else if (!to_fire)
         to_cnt_r <= to_cnt_r + TO_W'(1);
   end

   assign to_fire = (to_cnt_r == TO_W'(TIMEOUT_CYCLES - 1));

   // High-speed mode holds from the master code until a stop or a timeout.
   always_ff @(posedge clock)
   begin
      if (reset || bus_stop || to_fire)
         high_speed_bus_mode <= 1'b0;
      else if (state_r == ST_ADDR && byte_done &&
               byte_in[7:3] == HS_CODE_PFX)
         high_speed_bus_mode <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writable registers.

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         settings <= SETTINGS_RST;
      end
      else if (wr_fire)
      begin
         case (ptr_r)
            PTR_CFG_WR: settings.configuration <= byte_in & MASK_CFG;
            PTR_RATE_WR: settings.conversion_rate <= byte_in & MASK_RATE;
            PTR_LHL_WR: settings.local_high_limit <= byte_in;
            PTR_LLL_WR: settings.local_low_limit <= byte_in;
            PTR_RHLH_WR: settings.remote_high_limit_high_byte <= byte_in;
            PTR_RLLH_WR: settings.remote_low_limit_high_byte <= byte_in;
            PTR_OFS_HI: settings.remote_offset_high_byte <= byte_in;
            PTR_OFS_LO: settings.remote_offset_low_byte <= byte_in & MASK_LO;
            PTR_RHLL: settings.remote_high_limit_low_byte <= byte_in & MASK_LO;
            PTR_RLLL: settings.remote_low_limit_low_byte <= byte_in & MASK_LO;
            PTR_RCRIT: settings.remote_critical_limit <= byte_in;
            PTR_LCRIT: settings.local_critical_limit <= byte_in;
            PTR_HYST: settings.critical_hysteresis <= byte_in;
            PTR_FAULT: settings.fault_count_and_timeout <= byte_in & MASK_FAULT;
            PTR_IDEAL: settings.ideality_correction <= byte_in;
            PTR_AVG: settings.averaging_control <= byte_in & MASK_AVG;
            default: settings <= settings;
         endcase
      end
   end

   // One-shot start and status-read pulses.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         one_shot_start <= 1'b0;
         status_read <= 1'b0;
      end
      else
      begin
         one_shot_start <= wr_fire && (ptr_r == PTR_ONE_SHOT);
         status_read <= rd_fire && (ptr_r == PTR_STATUS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature results with pair locking.

   logic [7:0] lt_hi_r;
   logic [3:0] lt_lo_r;
   logic [7:0] rt_hi_r;
   logic [3:0] rt_lo_r;
   logic lk_l_hi_r;
   logic lk_l_lo_r;
   logic lk_r_hi_r;
   logic lk_r_lo_r;

   // A locked byte keeps its value until any register other than its partner is read.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         lt_hi_r <= 8'h00;
         lt_lo_r <= 4'h0;
         rt_hi_r <= 8'h00;
         rt_lo_r <= 4'h0;
      end
      else if (temp_update)
      begin
         if (!lk_l_hi_r)
            lt_hi_r <= temps.local_temp[11:4];
         if (!lk_l_lo_r)
            lt_lo_r <= temps.local_temp[3:0];
         if (!lk_r_hi_r)
            rt_hi_r <= temps.remote_temp[11:4];
         if (!lk_r_lo_r)
            rt_lo_r <= temps.remote_temp[3:0];
      end
   end

   // Reading an unlocked half locks the other; reading elsewhere frees all.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         lk_l_hi_r <= 1'b0;
         lk_l_lo_r <= 1'b0;
         lk_r_hi_r <= 1'b0;
         lk_r_lo_r <= 1'b0;
      end
      else if (rd_fire)
      begin
         lk_l_hi_r <= (ptr_r == PTR_LT_LO) && !lk_l_lo_r;
         lk_l_lo_r <= (ptr_r == PTR_LT_HI) && !lk_l_hi_r;
         lk_r_hi_r <= (ptr_r == PTR_RT_LO) && !lk_r_lo_r;
         lk_r_lo_r <= (ptr_r == PTR_RT_HI) && !lk_r_hi_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer selected by the stored pointer.

   always_comb
   begin
      case (ptr_r)
         PTR_LT_HI: rd_data = lt_hi_r;
         PTR_RT_HI: rd_data = rt_hi_r;
         PTR_STATUS: rd_data = status_flags;
         PTR_CFG_RD: rd_data = settings.configuration;
         PTR_RATE_RD: rd_data = settings.conversion_rate;
         PTR_LHL_RD: rd_data = settings.local_high_limit;
         PTR_LLL_RD: rd_data = settings.local_low_limit;
         PTR_RHLH_RD: rd_data = settings.remote_high_limit_high_byte;
         PTR_RLLH_RD: rd_data = settings.remote_low_limit_high_byte;
         PTR_RT_LO: rd_data = {rt_lo_r, 4'h0};
         PTR_OFS_HI: rd_data = settings.remote_offset_high_byte;
         PTR_OFS_LO: rd_data = settings.remote_offset_low_byte;
         PTR_RHLL: rd_data = settings.remote_high_limit_low_byte;
         PTR_RLLL: rd_data = settings.remote_low_limit_low_byte;
         PTR_LT_LO: rd_data = {lt_lo_r, 4'h0};
         PTR_RCRIT: rd_data = settings.remote_critical_limit;
         PTR_LCRIT: rd_data = settings.local_critical_limit;
         PTR_HYST: rd_data = settings.critical_hysteresis;
         PTR_FAULT: rd_data = settings.fault_count_and_timeout | FAULT_FIXED;
         PTR_IDEAL: rd_data = settings.ideality_correction;
         PTR_AVG: rd_data = settings.averaging_control;
         PTR_MAKER: rd_data = MAKER_ID;
         default: rd_data = 8'h00;
      endcase
   end

endmodule : tsp_smbus_slave

`default_nettype wire

// ===== tsp_pkg.sv
// Behaviour
// - Address byte: seven address bits, then direction.
// - Answer only the one fixed slave address.
// - First written byte loads the pointer.
// - Reads return the register the pointer selects.
// - Pointer-only write is accepted to retarget reads.
// - Pointer holds across reads until next write.
// - Data leaves most significant bit first.
// - Stuck low line resets the interface when enabled.
// - Timeout enable is fault register bit seven.
// - High-speed code is not acknowledged, sets high-speed.
// - Stop returns the filters to fast mode.
// - Write to pointer 0F starts one conversion.
// - Pointer resets to zero.
// - Pair bytes of a result stay locked together.
`default_nettype none
package tsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Pointer values; read and write pointers differ for low offsets.
   localparam logic [7:0] PTR_LT_HI = 8'h00;
   localparam logic [7:0] PTR_RT_HI = 8'h01;
   localparam logic [7:0] PTR_STATUS = 8'h02;
   localparam logic [7:0] PTR_CFG_RD = 8'h03;
   localparam logic [7:0] PTR_RATE_RD = 8'h04;
   localparam logic [7:0] PTR_LHL_RD = 8'h05;
   localparam logic [7:0] PTR_LLL_RD = 8'h06;
   localparam logic [7:0] PTR_RHLH_RD = 8'h07;
   localparam logic [7:0] PTR_RLLH_RD = 8'h08;
   localparam logic [7:0] PTR_CFG_WR = 8'h09;
   localparam logic [7:0] PTR_RATE_WR = 8'h0a;
   localparam logic [7:0] PTR_LHL_WR = 8'h0b;
   localparam logic [7:0] PTR_LLL_WR = 8'h0c;
   localparam logic [7:0] PTR_RHLH_WR = 8'h0d;
   localparam logic [7:0] PTR_RLLH_WR = 8'h0e;
   localparam logic [7:0] PTR_ONE_SHOT = 8'h0f;
   localparam logic [7:0] PTR_RT_LO = 8'h10;
   localparam logic [7:0] PTR_OFS_HI = 8'h11;
   localparam logic [7:0] PTR_OFS_LO = 8'h12;
   localparam logic [7:0] PTR_RHLL = 8'h13;
   localparam logic [7:0] PTR_RLLL = 8'h14;
   localparam logic [7:0] PTR_LT_LO = 8'h15;
   localparam logic [7:0] PTR_RCRIT = 8'h19;
   localparam logic [7:0] PTR_LCRIT = 8'h20;
   localparam logic [7:0] PTR_HYST = 8'h21;
   localparam logic [7:0] PTR_FAULT = 8'h22;
   localparam logic [7:0] PTR_IDEAL = 8'h23;
   localparam logic [7:0] PTR_AVG = 8'h24;
   localparam logic [7:0] PTR_MAKER = 8'hfe;
   localparam logic [7:0] PTR_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Writable bit masks, fixed bits and field positions.
   localparam logic [7:0] MASK_CFG = 8'he4;
   localparam logic [7:0] MASK_RATE = 8'h0f;
   localparam logic [7:0] MASK_LO = 8'hf0;
   localparam logic [7:0] MASK_FAULT = 8'h8e;
   localparam logic [7:0] FAULT_FIXED = 8'h01;
   localparam logic [7:0] MASK_AVG = 8'h03;
   localparam int TIMEOUT_EN_BIT = 7;
   localparam logic [4:0] HS_CODE_PFX = 5'h01;

   // Factory address variants.
   localparam logic [6:0] ADDR_VAR_A = 7'h49;
   localparam logic [6:0] ADDR_VAR_B = 7'h4c;
   localparam logic [6:0] ADDR_VAR_C = 7'h4e;

   // Reset values of the writable registers.
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h08;
   localparam logic [7:0] RST_HLIM = 8'h55;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CRIT = 8'h6e;
   localparam logic [7:0] RST_HYST = 8'h0a;
   localparam logic [7:0] RST_FAULT = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: bus stuck timeout.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TIMEOUT_MS = 25;
   localparam int unsigned TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
   localparam int TO_W = 22;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef struct packed {
      logic [7:0] configuration;
      logic [7:0] conversion_rate;
      logic [7:0] local_high_limit;
      logic [7:0] local_low_limit;
      logic [7:0] remote_high_limit_high_byte;
      logic [7:0] remote_low_limit_high_byte;
      logic [7:0] remote_offset_high_byte;
      logic [7:0] remote_offset_low_byte;
      logic [7:0] remote_high_limit_low_byte;
      logic [7:0] remote_low_limit_low_byte;
      logic [7:0] remote_critical_limit;
      logic [7:0] local_critical_limit;
      logic [7:0] critical_hysteresis;
      logic [7:0] fault_count_and_timeout;
      logic [7:0] ideality_correction;
      logic [7:0] averaging_control;
   } tsp_settings_s;

   localparam tsp_settings_s SETTINGS_RST = '{
      RST_CFG, RST_RATE, RST_HLIM, RST_ZERO, RST_HLIM, RST_ZERO,
      RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_CRIT, RST_CRIT,
      RST_HYST, RST_FAULT, RST_ZERO, RST_ZERO};

   typedef struct packed {
      logic [11:0] local_temp;
      logic [11:0] remote_temp;
   } tsp_temp_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_RX = 3'h2,
      ST_TX = 3'h6,
      ST_MACK = 3'h7,
      ST_WAIT = 3'h5
   } tsp_state_e;

endpackage : tsp_pkg

`default_nettype wire

// ===== tsp_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bus pin; idles at the given level.
module tsp_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic pin,
   output var logic level
);

   logic meta_r;

   // The first flop is read only by the second.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         meta_r <= RST_VAL;
         level <= RST_VAL;
      end
      else
      begin
         meta_r <= pin;
         level <= meta_r;
      end
   end

endmodule : tsp_sync

`default_nettype wire

// ===== tsp_smbus_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the slave port pins and register outputs.
module tsp_smbus_monitor #(
   parameter int unsigned TIMEOUT_CYCLES = 200
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire tsp_pkg::tsp_temp_s temps,
   input wire logic temp_update,
   input wire logic [7:0] status_flags,
   input wire tsp_pkg::tsp_settings_s settings,
   input wire logic high_speed_bus_mode,
   input wire logic one_shot_start,
   input wire logic status_read
);
   import tsp_pkg::*;

   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   // Counts the cycles that the bus clock has been held low.
   logic [23:0] low_cnt_r;
   always_ff @(posedge clock)
   begin
      if (reset || scl_in)
         low_cnt_r <= '0;
      else if (low_cnt_r != 24'hffffff)
         low_cnt_r <= low_cnt_r + 24'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Properties of the port.
   a_reset_idle: assert property (disable iff (1'b0) reset |=> !sda_oe &&
      !high_speed_bus_mode && settings == SETTINGS_RST) else $error("not idle after reset");
   a_drive_low: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
   a_oe_clock_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
      else $error("sda changed while clock high");
   a_write_on_high: assert property ($changed(settings) |-> scl_in)
      else $error("register changed off a bit sample");
   a_cfg_reserved: assert property ((settings.configuration & ~MASK_CFG) == 8'h00)
      else $error("reserved configuration bit set");
   a_shot_pulse: assert property (one_shot_start |-> scl_in ##1 !one_shot_start)
      else $error("one shot pulse wrong");
   a_status_pulse: assert property (status_read |-> !scl_in ##1 !status_read)
      else $error("status read pulse wrong");
   a_hs_no_ack: assert property ($rose(high_speed_bus_mode) |-> !sda_oe [*8])
      else $error("high speed code acknowledged");
   a_hs_on_stop: assert property ($fell(high_speed_bus_mode) &&
      !settings.fault_count_and_timeout[7] |-> $past(scl_in, 3)) else $error("mode left early");
   a_timeout_free: assert property (settings.fault_count_and_timeout[7] &&
      {8'h00, low_cnt_r} > TIMEOUT_CYCLES + 32'd8 |-> !sda_oe) else $error("bus not released");

endmodule : tsp_smbus_monitor

bind tsp_smbus_slave tsp_smbus_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_monitor (
   .clock(clock), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .temps(temps), .temp_update(temp_update), .status_flags(status_flags),
   .settings(settings), .high_speed_bus_mode(high_speed_bus_mode),
   .one_shot_start(one_shot_start), .status_read(status_read));

`default_nettype wire

// ===== tsp_bus_master.sv
`timescale 1ns/1ns
`default_nettype none

// Bus master model; SCL phases are eight cycles, SDA moves mid low phase.
module tsp_bus_master (
   input wire logic clock,
   input wire logic sda_line,
   output var logic scl,
   output var logic sda_low
);
   // Both lines idle released.
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   // SDA falls while SCL is high, also as a repeated start.
   task start;
      idle(4);
      sda_low = 1'b0;
      idle(4);
      scl = 1'b1;
      idle(8);
      sda_low = 1'b1;
      idle(8);
      scl = 1'b0;
   endtask : start

   // SDA rises while SCL is high.
   task stop;
      idle(4);
      sda_low = 1'b1;
      idle(4);
      scl = 1'b1;
      idle(8);
      sda_low = 1'b0;
      idle(8);
   endtask : stop

   // Nine bits most significant first; the last is the acknowledge slot.
   task xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         idle(4);
         sda_low = ~d[i];
         idle(4);
         scl = 1'b1;
         idle(4);
         q[i] = sda_line;
         idle(4);
         scl = 1'b0;
      end
   endtask : xfer
endmodule : tsp_bus_master

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %h, expected %h", $time, a, b); end end

// Drives the slave port through the master model and checks replies.
module testbench;
   import tsp_pkg::*;

   localparam int unsigned TO_CYC = 1000; // Longer than any run of zero bits in a transfer.
   localparam logic [7:0] MAKER = 8'h2b; // Value is arbitrary.
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic scl, sda_low, sda_oe, sda_out, temp_update, hs, shot, sread;
   logic [7:0] status_flags, v, d;
   logic [8:0] q;
   tsp_temp_s temps, old;
   tsp_settings_s settings;
   wire logic sda_line;
   int num_errors = 0;
   int checks_done = 0;
   int n_shot = 0;
   int n;
   logic [7:0] rst_p [11] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22,
      8'hfe, 8'h0f, 8'h02};
   logic [7:0] rst_v [11] = '{8'h00, 8'h08, 8'h55, 8'h55, 8'h6e, 8'h6e, 8'h0a, 8'h01,
      MAKER, 8'h00, 8'h00};
   logic [7:0] wp [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h12, 8'h13, 8'h21, 8'h22, 8'h24};
   logic [7:0] rp [9] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h12, 8'h13, 8'h21, 8'h22, 8'h24};
   logic [7:0] mk [9] = '{8'he4, 8'h0f, 8'hff, 8'hff, 8'hf0, 8'hf0, 8'hff, 8'h8e, 8'h03};
   logic [6:0] bad [3] = '{7'h49, 7'h4e, 7'h4d};

   // Pull-up resolves the open-drain data line.
   assign sda_line = ~sda_low & ~(sda_oe & ~sda_out);
   always #5 clock = ~clock;
   always @(posedge clock) if (shot === 1'b1) n_shot++;

   tsp_smbus_slave #(.SLAVE_ADDR(ADDR_VAR_B), .MAKER_ID(MAKER), .TIMEOUT_CYCLES(TO_CYC)) u_dut (
      .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .temps(temps), .temp_update(temp_update), .status_flags(status_flags),
      .settings(settings), .high_speed_bus_mode(hs), .one_shot_start(shot),
      .status_read(sread));
   tsp_bus_master u_master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

   ////////////////////////////////////////////////////////////////////////////
   // Bus transactions.
   task send(input logic [7:0] b, input logic ack);
      u_master.xfer({b, 1'b1}, q);
      `CHK(q[0], ~ack)
   endtask : send

   task wr(input logic [7:0] p, input logic [7:0] dat, input logic has_d);
      u_master.start();
      send({ADDR_VAR_B, 1'b0}, 1'b1);
      send(p, 1'b1);
      if (has_d)
         send(dat, 1'b1);
      u_master.stop();
   endtask : wr

   task rd_now(output logic [7:0] val);
      u_master.start();
      send({ADDR_VAR_B, 1'b1}, 1'b1);
      u_master.xfer(9'h1ff, q);
      val = q[8:1];
      u_master.stop();
   endtask : rd_now

   task rd(input logic [7:0] p, output logic [7:0] val);
      wr(p, 8'h00, 1'b0);
      rd_now(val);
   endtask : rd

   task pulse;
      temp_update = 1'b1;
      u_master.idle(1);
      temp_update = 1'b0;
   endtask : pulse

   task complete_run;
      $display("errors %0d, checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   // Cuts a hang short.
   initial
   begin
      repeat (100000) @(posedge clock);
      num_errors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      v = 8'($urandom(32'hfc5c7e0d));
      temps = '0;
      temp_update = 1'b0;
      status_flags = 8'($urandom());
      rst_v[10] = status_flags;
      repeat (2) @(posedge clock);
      #1 reset = 1'b0;
      u_master.idle(4);
      rd_now(v);
      `CHK(v, 8'h00)
      foreach (rst_p[i])
      begin
         rd(rst_p[i], v);
         `CHK(v, rst_v[i])
      end
      foreach (bad[i])
      begin
         u_master.start();
         send({bad[i], 1'b0}, 1'b0);
         u_master.stop();
      end
      foreach (wp[i])
      begin
         d = 8'($urandom());
         wr(wp[i], d, 1'b1);
         rd(rp[i], v);
         `CHK(v, (d & mk[i]) | (rp[i] == 8'h22 ? 8'h01 : 8'h00))
         rd_now(v);
         `CHK(v, (d & mk[i]) | (rp[i] == 8'h22 ? 8'h01 : 8'h00))
      end
      wr(8'h00, 8'($urandom()), 1'b1);
      rd_now(v);
      `CHK(v, 8'h00)
      n = n_shot;
      wr(8'h0f, 8'($urandom()), 1'b1);
      `CHK(n_shot, n + 1)
      rd(8'h15, v);
      `CHK(v, 8'h00)
      temps = tsp_temp_s'(24'($urandom()));
      pulse();
      rd(8'h00, v);
      `CHK(v, temps.local_temp[11:4])
      rd(8'h01, v);
      `CHK(v, temps.remote_temp[11:4])
      rd(8'h10, v);
      `CHK(v, {temps.remote_temp[3:0], 4'h0})
      rd(8'h00, v);
      old = temps;
      temps = ~temps;
      pulse();
      rd(8'h15, v);
      `CHK(v, {old.local_temp[3:0], 4'h0})
      for (int k = 0; k < 8; k++)
      begin
         u_master.start();
         send(8'h08 | 8'(k), 1'b0);
         `CHK(hs, 1'b1)
         u_master.start();
         send({ADDR_VAR_B, 1'b0}, 1'b1);
         send(8'h03, 1'b1);
         u_master.stop();
         `CHK(hs, 1'b0)
      end
      wr(8'h22, 8'h80, 1'b1);
      wr(8'h0c, 8'h00, 1'b1);
      u_master.start();
      send({ADDR_VAR_B, 1'b1}, 1'b1);
      u_master.idle(10);
      `CHK(sda_oe, 1'b1)
      u_master.idle(TO_CYC + 20);
      `CHK(sda_oe, 1'b0)
      u_master.stop();
      rd(8'h22, v);
      `CHK(v, 8'h81)
      // Two bytes in one read repeat the same register.
      u_master.start();
      send({ADDR_VAR_B, 1'b1}, 1'b1);
      u_master.xfer(9'h1fe, q);
      `CHK(q[8:1], 8'h81)
      u_master.xfer(9'h1ff, q);
      `CHK(q[8:1], 8'h81)
      u_master.stop();
      complete_run();
   end
endmodule : testbench

`default_nettype wire
